// ---- core/rsw_switch_slave.sv ----
// Serial register slave steering a ten-throw antenna switch.
`timescale 1ns/1ns
`include "rsw_params.svh"
module rsw_switch_slave import rsw_pkg::*; #(
    parameter logic [7:0] PART_CODE = `RSW_PART_CODE,
    parameter logic [9:0] MAKER_CODE = `RSW_MAKER_CODE
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic sclk,
    input wire logic sdata_in,
    output logic sdata_out,
    output logic sdata_oe,
    output logic [9:0] throw_sel,
    output logic low_power
);
    // The identity code defaults are arbitrary values.
    rsw_state_t st_reg;
    rsw_state_t st_next;
    logic [1:0] pins_s;
    logic sclk_s;
    logic sdata_s;
    logic rise;
    logic fall;
    logic ssc;
    logic wr_en;
    logic [4:0] wr_addr;
    logic [7:0] wr_data;
    logic [12:0] cmd_full;
    logic [8:0] data_full;

    localparam rsw_state_t ST_RESET = '{
        phase: RSW_IDLE, cnt: 4'h0, sclk_d: 1'b0, sdata_d: 1'b0,
        cmd_sh: 13'h0000, data_sh: 9'h000, rd_sh: 9'h000,
        sd_out: 1'b0, sd_oe: 1'b0, mode: `RSW_MODE_DEF,
        shadow: `RSW_MODE_DEF, low_power: 1'b0, mask: `RSW_MASK_DEF,
        unique_slave_id: `RSW_UNIQUE_SLAVE_ID_DEF, throws: 10'h000};

    // Returns one for frames that carry odd parity.
    function automatic logic rsw_odd_ok(input logic [12:0] bits);
        rsw_odd_ok = ^bits;
    endfunction : rsw_odd_ok

    // Read data for a register address; reserved bits read zero.
    function automatic logic [7:0] rsw_read(input logic [4:0] addr,
                                            input rsw_state_t s);
        case (addr)
            `RSW_ADDR_MODE: rsw_read = s.mode;
            `RSW_ADDR_PWR: rsw_read = {s.low_power, 1'b0, s.mask, 3'h0};
            `RSW_ADDR_PART: rsw_read = PART_CODE;
            `RSW_ADDR_MAKER_LO: rsw_read = MAKER_CODE[7:0];
            `RSW_ADDR_MAKER_HI: rsw_read = {2'h0, MAKER_CODE[9:8], s.unique_slave_id};
            default: rsw_read = 8'h00;
        endcase
    endfunction : rsw_read

    // Maps the mode byte onto a one-hot or all-zero throw select.
    function automatic logic [9:0] rsw_decode(input logic [7:0] m);
        rsw_decode = 10'h000;
        if (m[5:0] != 6'h00 && !m[4]) begin
            case (m[3:0])
                4'h2: rsw_decode = 10'h001;
                4'ha: rsw_decode = 10'h002;
                4'he: rsw_decode = 10'h004;
                4'hb: rsw_decode = 10'h008;
                4'h1: rsw_decode = 10'h010;
                4'h9: rsw_decode = 10'h020;
                4'h6: rsw_decode = 10'h040;
                4'h4: rsw_decode = 10'h080;
                4'hc: rsw_decode = 10'h100;
                4'h8: rsw_decode = 10'h200;
                default: rsw_decode = 10'h000;
            endcase
        end
    endfunction : rsw_decode

    rsw_sync #(.WIDTH(2)) u_sync (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .async_in({sclk, sdata_in}),
        .sync_out(pins_s)
    );

    assign sclk_s = pins_s[1];
    assign sdata_s = pins_s[0];
    assign rise = sclk_s && !st_reg.sclk_d;
    assign fall = !sclk_s && st_reg.sclk_d;
    assign ssc = !sclk_s && !st_reg.sclk_d && !sdata_s && st_reg.sdata_d;
    assign cmd_full = {st_reg.cmd_sh[11:0], sdata_s};
    assign data_full = {st_reg.data_sh[7:0], sdata_s};

    always_comb begin
        st_next = st_reg;
        wr_en = 1'b0;
        wr_addr = 5'h00;
        wr_data = 8'h00;
        st_next.sclk_d = sclk_s;
        st_next.sdata_d = sdata_s;
        if (ssc) begin
            st_next.phase = RSW_CMD;
            st_next.cnt = 4'h0;
            st_next.sd_oe = 1'b0;
        end else begin
            case (st_reg.phase)
                RSW_CMD: begin
                    if (fall) begin
                        st_next.cmd_sh = cmd_full;
                        st_next.cnt = st_reg.cnt + 4'h1;
                        if (st_reg.cnt == `RSW_CMD_LAST) begin
                            st_next.phase = RSW_IDLE;
                            st_next.cnt = 4'h0;
                            if (rsw_odd_ok(cmd_full) && cmd_full[12:9] == st_reg.unique_slave_id) begin
                                if (cmd_full[8]) begin
                                    wr_en = 1'b1;
                                    wr_data = {1'b0, cmd_full[7:1]};
                                end else if (cmd_full[7:6] == 2'b10) begin
                                    st_next.phase = RSW_DATA;
                                end else if (cmd_full[7:6] == 2'b11) begin
                                    st_next.phase = RSW_RD;
                                    st_next.rd_sh = {rsw_read(cmd_full[5:1], st_reg),
                                        ~^rsw_read(cmd_full[5:1], st_reg)};
                                end
                            end
                        end
                    end
                end
                RSW_DATA: begin
                    if (fall) begin
                        st_next.data_sh = data_full;
                        st_next.cnt = st_reg.cnt + 4'h1;
                        if (st_reg.cnt == `RSW_DATA_LAST) begin
                            st_next.phase = RSW_IDLE;
                            if (rsw_odd_ok({4'h0, data_full})) begin
                                wr_en = 1'b1;
                                wr_addr = st_reg.cmd_sh[5:1];
                                wr_data = data_full[8:1];
                            end
                        end
                    end
                end
                RSW_RD: begin
                    if (rise) begin
                        st_next.cnt = st_reg.cnt + 4'h1;
                        if (st_reg.cnt == `RSW_RD_LAST) begin
                            st_next.sd_oe = 1'b0;
                            st_next.phase = RSW_IDLE;
                        end else if (st_reg.cnt != 4'h0) begin
                            st_next.sd_oe = 1'b1;
                            st_next.sd_out = st_reg.rd_sh[8];
                            st_next.rd_sh = {st_reg.rd_sh[7:0], 1'b0};
                        end
                    end
                end
                default: begin
                    st_next.phase = RSW_IDLE;
                end
            endcase
        end
        if (wr_en) begin
            case (wr_addr)
                `RSW_ADDR_MODE: begin
                    st_next.shadow = wr_data;
                    if (&st_reg.mask) begin
                        st_next.mode = wr_data;
                    end
                end
                `RSW_ADDR_PWR: begin
                    st_next.low_power = wr_data[`RSW_LOWP_BIT];
                    st_next.mask = wr_data[5:3];
                    if (|(wr_data[2:0] & ~st_reg.mask)) begin
                        st_next.mode = st_reg.shadow;
                    end
                    if (wr_data[`RSW_STARTUP_BIT]) begin
                        st_next.mode = `RSW_MODE_DEF;
                        st_next.shadow = `RSW_MODE_DEF;
                        st_next.low_power = 1'b0;
                        st_next.mask = `RSW_MASK_DEF;
                        st_next.unique_slave_id = `RSW_UNIQUE_SLAVE_ID_DEF;
                    end
                end
                `RSW_ADDR_MAKER_HI: st_next.unique_slave_id = wr_data[3:0];
                default: begin
                end
            endcase
        end
        st_next.throws = rsw_decode(st_reg.mode);
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            st_reg <= ST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign sdata_out = st_reg.sd_out;
    assign sdata_oe = st_reg.sd_oe;
    assign throw_sel = st_reg.throws;
    assign low_power = st_reg.low_power;

    property p_oe_in_read;
        @(posedge ref_clk) disable iff (!nrst)
        sdata_oe |-> st_reg.phase == RSW_RD;
    endproperty
    a_oe_in_read: assert property (p_oe_in_read) else $error("drive outside read");

    property p_write_owner;
        @(posedge ref_clk) disable iff (!nrst)
        wr_en |-> st_reg.cmd_sh[11:8] == st_reg.unique_slave_id || st_reg.cmd_sh[12:9] == st_reg.unique_slave_id;
    endproperty
    a_write_owner: assert property (p_write_owner) else $error("foreign write");

    property p_direct;
        @(posedge ref_clk) disable iff (!nrst)
        wr_en && wr_addr == `RSW_ADDR_MODE && &st_reg.mask
        |=> st_reg.mode == $past(wr_data);
    endproperty
    a_direct: assert property (p_direct) else $error("masked write lost");

    property p_held;
        @(posedge ref_clk) disable iff (!nrst)
        wr_en && wr_addr == `RSW_ADDR_MODE && !(&st_reg.mask)
        |=> $stable(st_reg.mode) && st_reg.shadow == $past(wr_data);
    endproperty
    a_held: assert property (p_held) else $error("shadow bypassed");

    property p_trigger;
        @(posedge ref_clk) disable iff (!nrst)
        wr_en && wr_addr == `RSW_ADDR_PWR && !wr_data[6]
        && (|(wr_data[2:0] & ~st_reg.mask))
        |=> st_reg.mode == $past(st_reg.shadow);
    endproperty
    a_trigger: assert property (p_trigger) else $error("trigger not loaded");

    property p_quiet;
        @(posedge ref_clk) disable iff (!nrst)
        !wr_en |=> $stable(st_reg.mode);
    endproperty
    a_quiet: assert property (p_quiet) else $error("mode moved alone");

    property p_startup;
        @(posedge ref_clk) disable iff (!nrst)
        wr_en && wr_addr == `RSW_ADDR_PWR && wr_data[6]
        |=> st_reg.mode == 8'h00 && st_reg.unique_slave_id == 4'hb && !low_power;
    endproperty
    a_startup: assert property (p_startup) else $error("startup failed");

    property p_throw;
        @(posedge ref_clk) disable iff (!nrst)
        st_reg.mode[5:0] == 6'h02 ##1 st_reg.mode[5:0] == 6'h02
        |-> throw_sel == 10'h001;
    endproperty
    a_throw: assert property (p_throw) else $error("throw decode wrong");

    property p_unique_slave_id;
        @(posedge ref_clk) disable iff (!nrst)
        wr_en && wr_addr == `RSW_ADDR_MAKER_HI
        |=> st_reg.unique_slave_id == $past(wr_data[3:0]);
    endproperty
    a_unique_slave_id: assert property (p_unique_slave_id) else $error("slave ID not written");
endmodule : rsw_switch_slave

// ---- core/rsw_params.svh ----
// Register offsets, field positions, reset values and frame counts.
`ifndef RSW_PARAMS_SVH
`define RSW_PARAMS_SVH
`define RSW_ADDR_MODE 5'h00
`define RSW_ADDR_PWR 5'h1c
`define RSW_ADDR_PART 5'h1d
`define RSW_ADDR_MAKER_LO 5'h1e
`define RSW_ADDR_MAKER_HI 5'h1f
`define RSW_MODE_DEF 8'h00
`define RSW_UNIQUE_SLAVE_ID_DEF 4'hb
`define RSW_MASK_DEF 3'h0
`define RSW_LOWP_BIT 7
`define RSW_STARTUP_BIT 6
`define RSW_CMD_LAST 4'hc
`define RSW_DATA_LAST 4'h8
`define RSW_RD_LAST 4'ha
`define RSW_PART_CODE 8'h5a
`define RSW_MAKER_CODE 10'h155
`endif

// ---- core/rsw_pkg.sv ----
// Types shared by the switch register slave.
package rsw_pkg;
    typedef enum logic [1:0] {
        RSW_IDLE,
        RSW_CMD,
        RSW_DATA,
        RSW_RD
    } rsw_phase_t;

    typedef struct packed {
        rsw_phase_t phase;
        logic [3:0] cnt;
        logic sclk_d;
        logic sdata_d;
        logic [12:0] cmd_sh;
        logic [8:0] data_sh;
        logic [8:0] rd_sh;
        logic sd_out;
        logic sd_oe;
        logic [7:0] mode;
        logic [7:0] shadow;
        logic low_power;
        logic [2:0] mask;
        logic [3:0] unique_slave_id;
        logic [9:0] throws;
    } rsw_state_t;
endpackage : rsw_pkg

// ---- core/rsw_sync.sv ----
// Two-flop synchroniser for inputs from outside the clock domain.
`timescale 1ns/1ns
module rsw_sync #(
    parameter int WIDTH = 2
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : rsw_sync

// ---- verif/rsw_bm.sv ----
// Bus master model for the switch register link.
`timescale 1ns/1ns
module rsw_bm (
    output logic sclk,
    output logic m_data,
    output logic m_oe,
    input wire logic bus_data,
    output logic [8:0] rd_data,
    output int rd_n
);
    initial begin
        sclk = 1'b0;
        m_data = 1'b0;
        m_oe = 1'b1;
    end
    task automatic tick(input logic b);
        m_data = b;
        sclk = 1'b1;
        #160;
        sclk = 1'b0;
        #160;
    endtask : tick
    task automatic frame(input logic [11:0] c, input logic bad);
        m_oe = 1'b1;
        m_data = 1'b0;
        #160;
        m_data = 1'b1;
        #160;
        m_data = 1'b0;
        #160;
        for (int i = 11; i >= 0; i--) begin
            tick(c[i]);
        end
        tick(~^c ^ bad);
    endtask : frame
    task automatic wr(input logic [11:0] c, input logic [1:0] bad,
                      input logic wd, input logic [7:0] d);
        frame(c, bad[1]);
        for (int i = 7; i >= 0 && wd; i--) begin
            tick(d[i]);
        end
        if (wd) begin
            tick(~^d ^ bad[0]);
        end
        tick(1'b0);
        m_oe = 1'b0;
        #160;
    endtask : wr
    task automatic rd(input logic [11:0] c);
        logic [8:0] rx;
        frame(c, 1'b0);
        for (int i = 0; i < 10; i++) begin
            // Park is driven low on the rise and released at the fall.
            m_data = 1'b0;
            sclk = 1'b1;
            #160;
            sclk = 1'b0;
            m_oe = 1'b0;
            #150;
            rx = {rx[7:0], bus_data};
            #10;
        end
        rd_data = rx;
        tick(1'b0);
        rd_n++;
    endtask : rd
endmodule : rsw_bm

// ---- verif/tb_top.sv ----
// Self-checking bench for the switch register slave.
`timescale 1ns/1ns
module tb_top;
    localparam logic [7:0] PART = 8'h3c; // Arbitrary identity value.
    localparam logic [9:0] MAKER = 10'h2a7; // Arbitrary identity value.
    localparam logic [3:0] SA = 4'hb;
    logic ref_clk, nrst, sclk, m_data, m_oe, sda, sdata_out, sdata_oe;
    logic low_power;
    logic [9:0] throw_sel, cur;
    logic [8:0] rd_data;
    logic [7:0] d, r;
    logic [8:0] rd_q[$];
    logic [10:0] th_q[$];
    logic [3:0] code [10] = '{4'h2, 4'ha, 4'he, 4'hb, 4'h1,
                              4'h9, 4'h6, 4'h4, 4'hc, 4'h8};
    int err_count, n_compared, seed, rd_n, look_n;
    rsw_switch_slave #(.PART_CODE(PART), .MAKER_CODE(MAKER))
        u_rsw_switch_slave (.ref_clk(ref_clk), .nrst(nrst), .sclk(sclk),
        .sdata_in(sda), .sdata_out(sdata_out), .sdata_oe(sdata_oe),
        .throw_sel(throw_sel), .low_power(low_power));
    rsw_bm u_rsw_bm (.sclk(sclk), .m_data(m_data), .m_oe(m_oe),
        .bus_data(sda), .rd_data(rd_data), .rd_n(rd_n));
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    always @(sdata_oe, sdata_out, m_oe, m_data) begin
        sda = sdata_oe ? sdata_out : (m_oe ? m_data : ~sda);
    end
    task automatic check(input logic [10:0] seen, input logic [10:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    always @(rd_n) check({2'b00, rd_data}, {2'b00, rd_q.pop_front()});
    always @(look_n) check({low_power, throw_sel}, th_q.pop_front());
    task automatic rd_exp(input logic [3:0] u, input logic [4:0] a,
                          input logic [7:0] e);
        rd_q.push_back({e, ~^e});
        u_rsw_bm.rd({u, 3'b011, a});
        check({10'h000, sdata_oe}, 11'h000);
    endtask : rd_exp
    task automatic wr(input logic [3:0] u, input logic [4:0] a,
                      input logic [7:0] v, input logic [1:0] bad);
        u_rsw_bm.wr({u, 3'b010, a}, bad, 1'b1, v);
    endtask : wr
    task automatic look(input logic lp, input logic [9:0] th);
        th_q.push_back({lp, th});
        look_n++;
    endtask : look
    task automatic ids(input logic [3:0] u);
        rd_exp(u, 5'h1d, PART);
        rd_exp(u, 5'h1e, MAKER[7:0]);
        rd_exp(u, 5'h1f, {2'b00, MAKER[9:8], u});
    endtask : ids
    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize
    initial begin
        #3000000;
        err_count++;
        summarize();
    end
    initial begin
        seed = 32'h0a4f;
        nrst = 1'b0;
        repeat (6) @(posedge ref_clk);
        #1 nrst = 1'b1;
        repeat (4) @(posedge ref_clk);
        #1;
        look(1'b0, 10'h000);
        rd_exp(SA, 5'h00, 8'h00);
        rd_exp(SA, 5'h1c, 8'h00);
        ids(SA);
        wr(SA, 5'h1d, ~PART, 2'b00);
        wr(SA, 5'h1e, ~MAKER[7:0], 2'b00);
        wr(SA, 5'h1f, 8'hfb, 2'b00);
        ids(SA);
        $display("test identity done");
        cur = 10'h000;
        for (int i = 0; i < 3; i++) begin
            wr(SA, 5'h00, {4'h0, code[i]}, 2'b00);
            look(1'b0, cur);
            wr(SA, 5'h1c, 8'h00, 2'b00);
            look(1'b0, cur);
            wr(SA, 5'h1c, 8'h01 << i, 2'b00);
            cur = 10'h001 << i;
            look(1'b0, cur);
        end
        rd_exp(SA, 5'h1c, 8'h00);
        $display("test shadow done");
        wr(SA, 5'h1c, 8'h38, 2'b00);
        rd_exp(SA, 5'h1c, 8'h38);
        for (int i = 0; i < 11; i++) begin
            r = $random(seed);
            d = (i == 0) ? {r[7:6], 6'h00} : {r[7:5], 1'b0, code[i-1]};
            cur = (i == 0) ? 10'h000 : 10'h001 << (i - 1);
            if (i % 2 == 1) begin
                u_rsw_bm.wr({SA, 1'b1, d[6:0]}, 2'b00, 1'b0, 8'h00);
            end else begin
                wr(SA, 5'h00, d, 2'b00);
            end
            look(1'b0, cur);
        end
        rd_exp(SA, 5'h00, d);
        wr(SA, 5'h00, 8'h02, 2'b01);
        wr(SA, 5'h00, 8'h02, 2'b10);
        wr(4'h3, 5'h00, 8'h02, 2'b00);
        look(1'b0, cur);
        $display("test mode done");
        wr(SA, 5'h1c, 8'hb8, 2'b00);
        look(1'b1, cur);
        rd_exp(SA, 5'h1c, 8'hb8);
        wr(SA, 5'h1f, 8'h05, 2'b00);
        ids(4'h5);
        wr(4'h5, 5'h1c, 8'h40, 2'b00);
        look(1'b0, 10'h000);
        ids(SA);
        rd_exp(SA, 5'h1c, 8'h00);
        rd_exp(SA, 5'h00, 8'h00);
        $display("test power done");
        summarize();
    end
endmodule : tb_top
